// ### hdl/sample_timer.sv
`default_nettype none
// Pulses once every 2^(sel+5) slow-clock ticks while enabled
module sample_timer
   import smon_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // Control
   input  wire logic                run,
   input  wire logic                tick,
   input  wire logic [SMP_W-1:0]    sel,
   // Result
   output logic                     sample
);
   logic [CNT_W-1:0] count_r;
   logic [CNT_W-1:0] limit;

   assign limit = CNT_W'((64'h1 << (sel + SMP_EXP_OFS)) - 64'h1);

   always_ff @(posedge clk) begin
      if (rst || !run) begin
         count_r <= '0;
         sample  <= 1'b0;
      end else begin
         sample <= 1'b0;
         if (tick) begin
            if (count_r >= limit) begin // RULE5
               count_r <= '0;
               sample  <= 1'b1;
            end else begin
               count_r <= count_r + 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### hdl/supply_monitor_osc_config_regs.sv
// Functional notes
// RULE1 - Done flag clear: reload trim every reset
// RULE2 - Power-on reset clears oscillator done flag
// RULE3 - Done flag set after fuse trim load
// RULE4 - Ten-bit oscillator trim value field
// RULE5 - Sample every 2^(sel+5) slow ticks
// RULE6 - On indicator read-only, follows enable
// RULE7 - Lock makes monitor register read-only
// RULE8 - Monitor done flag cleared, set after load
// RULE9 - Four-bit monitor trim in bits 11:8
// RULE10 - Force bit: sampling always, else deep sleep
// RULE11 - Mode decode: 1 reset, 2 no-reset
// RULE12 - Interrupt request only when mask set
// RULE13 - Temperature sensor enable bit, reset zero
// RULE14 - Fast oscillator enable bit, reset zero
// RULE15 - On indicator from decoded mode 1 or 2
`default_nettype none
module supply_monitor_osc_config_regs
   import smon_cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   porEvent,
   // Wishbone slave
   input  wire logic                   wb_cyc_i,
   input  wire logic                   wb_stb_i,
   input  wire logic                   wb_we_i,
   input  wire logic [7:0]             wb_adr_i,
   input  wire logic [3:0]             wb_sel_i,
   input  wire logic [31:0]            wb_dat_i,
   output logic [31:0]                 wb_dat_o,
   output logic                        wb_ack_o,
   // Fuse values
   input  wire logic [TRIM_W-1:0]      fuseSysTrim,
   input  wire logic [SM_TRIM_W-1:0]   fuseSmTrim,
   // Analog side
   input  wire logic                   slowTick,
   input  wire logic                   deepSleepLevel,
   input  wire logic                   monitorTrip,
   input  wire logic                   interruptMaskBit,
   output logic [TRIM_W-1:0]           systemRcOscTrim,
   output logic [SM_TRIM_W-1:0]        monitorTrim,
   output logic                        monitorEnable,
   output logic                        monitorSample,
   output logic                        monitorResetReq,
   output logic                        monitorIrqReq,
   output logic                        tempSensorEnable,
   output logic                        fastRcOscEnable
);
   // ******************************************
   // State
   // ******************************************
   load_e                  loadState_r;
   logic [TRIM_W-1:0]      sysTrim_r;
   logic                   sysDone_r;
   logic [SM_TRIM_W-1:0]   smTrim_r;
   logic                   smDone_r;
   logic [SMP_W-1:0]       sampleSel_r;
   logic                   forceSampling_r;
   logic                   finalValueLock_r;
   logic [MODE_W-1:0]      mode_r;
   logic                   tempEn_r;
   logic                   fastEn_r;
   logic                   slowSync1_r;
   logic                   slowSync2_r;
   logic                   slowPrev_r;
   logic                   sleepSync1_r;
   logic                   sleepSync2_r;
   logic                   tripSync1_r;
   logic                   tripSync2_r;
   logic                   sampleRun;
   logic                   samplePulse;
   logic                   monitorOn;
   logic                   wbReq;
   logic                   wrSmon;
   logic [31:0]            rdData;
   logic [31:0]            wMask;
   logic [31:0]            smonWord;

   assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   assign smonWord = wb_dat_i & wMask;
   assign wrSmon = wbReq && wb_we_i && (wb_adr_i == OFS_SMON)
                   && !finalValueLock_r; // RULE7

   // Modes 0, 3 and reserved codes leave the monitor off
   assign monitorOn = (mode_r == MODE_RESET) || (mode_r == MODE_IRQ);
   // RULE15 RULE11

   // ******************************************
   // Input synchronisers
   // ******************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         slowSync1_r  <= 1'b0;
         slowSync2_r  <= 1'b0;
         slowPrev_r   <= 1'b0;
         sleepSync1_r <= 1'b0;
         sleepSync2_r <= 1'b0;
         tripSync1_r  <= 1'b0;
         tripSync2_r  <= 1'b0;
      end else begin
         slowSync1_r  <= slowTick;
         slowSync2_r  <= slowSync1_r;
         slowPrev_r   <= slowSync2_r;
         sleepSync1_r <= deepSleepLevel;
         sleepSync2_r <= sleepSync1_r;
         tripSync1_r  <= monitorTrip;
         tripSync2_r  <= tripSync1_r;
      end
   end

   // ******************************************
   // Fuse load sequence
   // ******************************************
   // Trim survives a plain reset once done; only power-on clears it
   always_ff @(posedge clk) begin
      if (porEvent) begin
         sysDone_r <= 1'b0; // RULE2
         sysTrim_r <= '0;
      end else if (loadState_r == LD_SYS) begin
         sysTrim_r <= fuseSysTrim; // RULE4
         sysDone_r <= 1'b1; // RULE3
      end
   end

   always_ff @(posedge clk) begin
      if (rst || porEvent) begin
         loadState_r <= LD_IDLE;
      end else begin
         unique case (loadState_r)
            LD_IDLE: loadState_r <= sysDone_r ? LD_SM : LD_SYS; // RULE1
            LD_SYS:  loadState_r <= LD_SM;
            LD_SM:   loadState_r <= LD_DONE;
            LD_DONE: loadState_r <= LD_DONE;
         endcase
      end
   end

   // ******************************************
   // Monitor configuration
   // ******************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         smTrim_r         <= '0;
         smDone_r         <= 1'b0; // RULE8
         sampleSel_r      <= '0;
         forceSampling_r  <= 1'b0;
         finalValueLock_r <= 1'b0; // RULE7
         mode_r           <= '0;
      end else begin
         // Fuse load wins over a write to the trim byte only
         if (loadState_r == LD_SM) begin
            smTrim_r <= fuseSmTrim; // RULE9
            smDone_r <= 1'b1; // RULE8
         end else if (wrSmon && wMask[SM_TRIM_LSB]) begin
            smTrim_r <= smonWord[SM_TRIM_LSB +: SM_TRIM_W];
         end
         // Unselected bytes keep their value; on and done ignore writes
         if (wrSmon && wMask[SMP_LSB]) begin
            sampleSel_r <= smonWord[SMP_LSB +: SMP_W];
         end
         if (wrSmon && wMask[LOCK_BIT]) begin
            finalValueLock_r <= smonWord[LOCK_BIT]; // RULE7
         end
         if (wrSmon && wMask[FORCE_BIT]) begin
            forceSampling_r <= smonWord[FORCE_BIT];
         end
         if (wrSmon && wMask[MODE_W-1]) begin
            mode_r <= smonWord[MODE_W-1:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         tempEn_r <= 1'b0; // RULE13
         fastEn_r <= 1'b0; // RULE14
      end else if (wbReq && wb_we_i && wb_sel_i[0]) begin
         if (wb_adr_i == OFS_TEMP) begin
            tempEn_r <= wb_dat_i[EN_BIT]; // RULE13
         end
         if (wb_adr_i == OFS_FASTRC) begin
            fastEn_r <= wb_dat_i[EN_BIT]; // RULE14
         end
      end
   end

   // ******************************************
   // Sampling
   // ******************************************
   assign sampleRun = monitorOn && (forceSampling_r || sleepSync2_r);
   // RULE10

   sample_timer u_timer (
      .clk    (clk),
      .rst    (rst),
      .run    (sampleRun),
      .tick   (slowSync2_r && !slowPrev_r),
      .sel    (sampleSel_r),
      .sample (samplePulse)
   );

   // ******************************************
   // Outputs
   // ******************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         systemRcOscTrim  <= '0;
         monitorTrim      <= '0;
         monitorEnable    <= 1'b0;
         monitorSample    <= 1'b0;
         monitorResetReq  <= 1'b0;
         monitorIrqReq    <= 1'b0;
         tempSensorEnable <= 1'b0;
         fastRcOscEnable  <= 1'b0;
      end else begin
         systemRcOscTrim  <= sysTrim_r;
         monitorTrim      <= smTrim_r;
         monitorEnable    <= monitorOn; // RULE6
         monitorSample    <= samplePulse; // RULE5
         monitorResetReq  <= (mode_r == MODE_RESET) && tripSync2_r;
         monitorIrqReq    <= monitorOn && tripSync2_r
                             && interruptMaskBit; // RULE12
         tempSensorEnable <= tempEn_r;
         fastRcOscEnable  <= fastEn_r;
      end
   end

   // ******************************************
   // Wishbone read and ack
   // ******************************************
   always_comb begin
      rdData = '0;
      unique case (wb_adr_i)
         OFS_SYSOSC: begin
            rdData[TRIM_W-1:0]   = sysTrim_r;
            rdData[SYS_DONE_BIT] = sysDone_r;
         end
         OFS_SMON: begin
            rdData[SMP_LSB +: SMP_W]         = sampleSel_r;
            rdData[ON_BIT]                   = monitorOn; // RULE6
            rdData[LOCK_BIT]                 = finalValueLock_r;
            rdData[SM_DONE_BIT]              = smDone_r;
            rdData[SM_TRIM_LSB +: SM_TRIM_W] = smTrim_r;
            rdData[FORCE_BIT]                = forceSampling_r;
            rdData[MODE_W-1:0]               = mode_r;
         end
         OFS_TEMP:   rdData[EN_BIT] = tempEn_r;
         OFS_FASTRC: rdData[EN_BIT] = fastEn_r;
         OFS_STATUS: begin
            rdData[EN_BIT]         = loadState_r == LD_DONE;
            rdData[STAT_RESET_BIT] = monitorResetReq;
            rdData[STAT_IRQ_BIT]   = monitorIrqReq;
            rdData[STAT_SAMP_BIT]  = sampleRun;
         end
         default: rdData = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= wbReq;
         wb_dat_o <= wbReq ? rdData : '0;
      end
   end

   // ******************************************
   // Checks
   // ******************************************
   sequence resetReleaseSeq;
      rst ##1 !rst;
   endsequence

   // Trim load takes two to three cycles, depending on the done flag
   sequence monitorLoadSeq;
      ##[1:3] smDone_r;
   endsequence

   sequence busAnswerSeq;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   lock_holds_a: assert property (@(posedge clk) disable iff (rst) // RULE7
      finalValueLock_r && !porEvent |=> $stable(mode_r))
      else $error("locked monitor register changed");
   on_follows_a: assert property (@(posedge clk) disable iff (rst) // RULE6
      monitorEnable == $past(monitorOn))
      else $error("on indicator wrong");
   irq_mask_a: assert property (@(posedge clk) disable iff (rst) // RULE12
      monitorIrqReq |-> $past(interruptMaskBit))
      else $error("irq without mask");
   por_clears_a: assert property (@(posedge clk) // RULE2
      porEvent |=> !sysDone_r)
      else $error("power-on reset left done flag set");
   sys_load_a: assert property (@(posedge clk) // RULE3
      disable iff (rst || porEvent)
      loadState_r == LD_SYS |=> sysDone_r && sysTrim_r == $past(fuseSysTrim))
      else $error("oscillator trim load wrong");
   sm_done_a: assert property (@(posedge clk) // RULE8
      resetReleaseSeq |-> monitorLoadSeq)
      else $error("monitor done flag not set after reset");
   reset_req_a: assert property (@(posedge clk) disable iff (rst) // RULE11
      monitorResetReq |-> $past(mode_r) == MODE_RESET)
      else $error("reset request outside reset mode");
   ack_once_a: assert property (@(posedge clk) disable iff (rst)
      wbReq |=> busAnswerSeq)
      else $error("bus answer not a single ack");
endmodule
`default_nettype wire

// ### pkg/smon_cfg_pkg.sv
`default_nettype none
package smon_cfg_pkg;
   // ******************************************
   // Register map (byte addresses)
   // ******************************************
   localparam logic [7:0] OFS_SYSOSC = 8'h00;
   localparam logic [7:0] OFS_SMON   = 8'h04;
   localparam logic [7:0] OFS_TEMP   = 8'h08;
   localparam logic [7:0] OFS_FASTRC = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // ******************************************
   // Field layout
   // ******************************************
   localparam int TRIM_W        = 10;
   localparam int SYS_DONE_BIT  = 16;
   localparam int SMP_LSB       = 24;
   localparam int SMP_W         = 4;
   localparam int ON_BIT        = 18;
   localparam int LOCK_BIT      = 17;
   localparam int SM_DONE_BIT   = 16;
   localparam int SM_TRIM_LSB   = 8;
   localparam int SM_TRIM_W     = 4;
   localparam int FORCE_BIT     = 7;
   localparam int MODE_W        = 3;
   localparam int EN_BIT        = 0;
   localparam int SMP_EXP_OFS   = 5;
   localparam int STAT_RESET_BIT = 1;
   localparam int STAT_IRQ_BIT   = 2;
   localparam int STAT_SAMP_BIT  = 3;

   // ******************************************
   // Monitor mode codes
   // ******************************************
   localparam logic [2:0] MODE_OFF0  = 3'h0;
   localparam logic [2:0] MODE_RESET = 3'h1;
   localparam logic [2:0] MODE_IRQ   = 3'h2;
   localparam logic [2:0] MODE_OFF3  = 3'h3;

   localparam logic [31:0] SMON_RESET = 32'h00000000;
   localparam int CNT_W = 24;

   typedef enum logic [1:0] {LD_IDLE, LD_SYS, LD_SM, LD_DONE} load_e;
endpackage
`default_nettype wire

// ### verification/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import smon_cfg_pkg::*;

   // ******************************************
   // Stimulus and observed signals
   // ******************************************
   logic                  clk;
   logic                  rst;
   logic                  porEvent;
   logic                  wbCyc;
   logic                  wbStb;
   logic                  wbWe;
   logic [7:0]            wbAdr;
   logic [3:0]            wbSel;
   logic [31:0]           wbDat;
   logic [31:0]           rdDat;
   logic                  wbAck;
   logic [TRIM_W-1:0]     fSys;
   logic [SM_TRIM_W-1:0]  fSm;
   logic                  slowTick;
   logic [2:0]            tickCnt;
   logic                  deep;
   logic                  trip;
   logic                  mask;
   logic [TRIM_W-1:0]     sysTrim;
   logic [SM_TRIM_W-1:0]  smTrim;
   logic                  monEn;
   logic                  smpl;
   logic                  rstReq;
   logic                  irqReq;
   logic                  tempEn;
   logic                  fastEn;
   logic [31:0]           rv;
   int                    errTotal;
   int                    numChecks;
   int                    cycles;

   supply_monitor_osc_config_regs u_dut (
      .clk(clk), .rst(rst), .porEvent(porEvent),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
      .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDat),
      .wb_dat_o(rdDat), .wb_ack_o(wbAck),
      .fuseSysTrim(fSys), .fuseSmTrim(fSm), .slowTick(slowTick),
      .deepSleepLevel(deep), .monitorTrip(trip),
      .interruptMaskBit(mask), .systemRcOscTrim(sysTrim),
      .monitorTrim(smTrim), .monitorEnable(monEn),
      .monitorSample(smpl), .monitorResetReq(rstReq),
      .monitorIrqReq(irqReq), .tempSensorEnable(tempEn),
      .fastRcOscEnable(fastEn));

   // ******************************************
   // Clock, slow tick and hang guard
   // ******************************************
   always #25 clk = ~clk;

   // Slow tick eight clocks per period keeps sample gaps short
   always @(posedge clk) begin
      tickCnt <= tickCnt + 3'h1;
      slowTick <= tickCnt[2];
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         errTotal++;
         giveVerdict();
      end
   end

   // ******************************************
   // Shared tasks
   // ******************************************
   task automatic giveVerdict();
      $display("checks %0d mismatches %0d", numChecks, errTotal);
      if (errTotal == 0 && numChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         errTotal++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // Request held until ack is sampled high at a rising edge
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s = 4'hf);
      @(posedge clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDat <= d;
      wbSel <= s;
      do @(posedge clk); while (wbAck !== 1'b1);
      rv = rdDat;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
   endtask

   task automatic doReset(input logic por);
      rst <= 1'b1;
      porEvent <= por;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      porEvent <= 1'b0;
      rv = 32'h0;
      for (int i = 0; i < 20 && rv[0] !== 1'b1; i++)
         xfer(1'b0, OFS_STATUS, 32'h0);
   endtask

   // Gap in clocks between two consecutive sample pulses
   task automatic measGap(input logic [31:0] cfg, input int exp);
      int n;
      xfer(1'b1, OFS_SMON, cfg);
      n = 0;
      while (smpl !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      @(posedge clk);
      n = 1;
      while (smpl !== 1'b1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk(n, exp);
   endtask

   // ******************************************
   // Scenarios
   // ******************************************
   task automatic testLoad();
      doReset(1'b1);
      xfer(1'b0, OFS_SYSOSC, 32'h0);
      chk(rv, 32'h000102a5);
      chk({22'h0, sysTrim}, 32'h000002a5);
      xfer(1'b0, OFS_SMON, 32'h0);
      chk(rv, 32'h00010900);
      chk({28'h0, smTrim}, 32'h00000009);
      fSys <= 10'h15a;
      fSm <= 4'h6;
      doReset(1'b0);
      xfer(1'b0, OFS_SYSOSC, 32'h0);
      chk(rv, 32'h000102a5);
      xfer(1'b0, OFS_SMON, 32'h0);
      chk(rv, 32'h00010600);
      doReset(1'b1);
      xfer(1'b0, OFS_SYSOSC, 32'h0);
      chk(rv, 32'h0001015a);
      $display("load test done");
   endtask

   task automatic testModes();
      logic [2:0] order [5] = '{3'h0, 3'h3, 3'h5, 3'h2, 3'h1};
      logic       on;
      trip <= 1'b1;
      foreach (order[i]) begin
         on = (order[i] == 3'h1) || (order[i] == 3'h2);
         xfer(1'b1, OFS_SMON, {29'h8000, order[i]});
         xfer(1'b0, OFS_SMON, 32'h0);
         chk(rv & 32'h00040007, {13'h0, on, 15'h0, order[i]});
         repeat (6) @(posedge clk);
         chk({31'h0, monEn}, {31'h0, on});
         chk({30'h0, rstReq, irqReq}, {30'h0, order[i] == 3'h1, 1'b0});
      end
      mask <= 1'b1;
      repeat (6) @(posedge clk);
      chk({31'h0, irqReq}, 32'h1);
      trip <= 1'b0;
      mask <= 1'b0;
      $display("mode test done");
   endtask

   task automatic testSampling();
      int cnt;
      measGap(32'h00000081, 256);
      measGap(32'h01000081, 512);
      xfer(1'b1, OFS_SMON, 32'h00000002);
      cnt = 0;
      repeat (600) begin
         @(posedge clk);
         cnt += (smpl === 1'b1);
      end
      chk(cnt, 0);
      deep <= 1'b1;
      measGap(32'h00000002, 256);
      xfer(1'b0, OFS_STATUS, 32'h0);
      chk(rv, 32'h00000009);
      deep <= 1'b0;
      $display("sampling test done");
   endtask

   task automatic testLockAndEnables();
      xfer(1'b1, OFS_SMON, 32'h00020002);
      xfer(1'b1, OFS_SMON, 32'h00000001);
      xfer(1'b0, OFS_SMON, 32'h0);
      chk(rv & 32'h00020007, 32'h00020002);
      doReset(1'b0);
      xfer(1'b0, OFS_SMON, 32'h0);
      chk(rv & 32'h00020007, 32'h0);
      xfer(1'b0, OFS_TEMP, 32'h0);
      chk(rv, 32'h0);
      xfer(1'b0, OFS_FASTRC, 32'h0);
      chk(rv, 32'h0);
      xfer(1'b1, OFS_TEMP, 32'h00000001);
      xfer(1'b1, OFS_FASTRC, 32'h00000001);
      xfer(1'b1, 8'h20, 32'h0);
      xfer(1'b0, 8'h20, 32'h0);
      chk(rv, 32'h0);
      xfer(1'b0, OFS_TEMP, 32'h0);
      chk(rv, 32'h00000001);
      chk({30'h0, tempEn, fastEn}, 32'h3);
      xfer(1'b1, OFS_FASTRC, 32'h0);
      xfer(1'b0, OFS_FASTRC, 32'h0);
      chk({rv[31:1], fastEn}, 32'h0);
      xfer(1'b1, OFS_TEMP, 32'h0, 4'he);
      xfer(1'b0, OFS_TEMP, 32'h0);
      chk(rv, 32'h00000001);
      xfer(1'b1, OFS_SMON, 32'h0f000f81, 4'h1);
      xfer(1'b0, OFS_SMON, 32'h0);
      chk(rv, 32'h00050681);
      $display("lock and enable test done");
   endtask

   initial begin
      clk = 1'b0;
      rst = 1'b1;
      porEvent = 1'b1;
      {wbCyc, wbStb, wbWe} = 3'h0;
      wbAdr = 8'h00;
      wbSel = 4'hf;
      wbDat = 32'h0;
      fSys = 10'h2a5;
      fSm = 4'h9;
      slowTick = 1'b0;
      tickCnt = 3'h0;
      {deep, trip, mask} = 3'h0;
      testLoad();
      testModes();
      testSampling();
      testLockAndEnables();
      giveVerdict();
   end
endmodule
`default_nettype wire
